// [hw/qrp_quad_read_program.sv]
`timescale 1ns/1ps
module qrp_quad_read_program #(
	parameter int CLEAR_LEN = qrp_pkg::MEM_BYTES
) (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Serial link from the host
	input wire logic serial_clk,
	input wire logic chip_sel_b,
	input wire logic [3:0] data_line_in,
	output logic [3:0] data_line_out,
	output logic [3:0] data_line_oe,
	// Configuration and protection
	input wire qrp_pkg::qrp_cfg_s link_cfg,
	input wire qrp_pkg::qrp_guard_s guard,
	// Status
	output logic write_in_progress,
	output logic opcode_skip_read,
	output logic program_started,
	output logic program_rejected
);

	localparam int AW = qrp_pkg::MEM_AW;
	localparam int PW = qrp_pkg::PAGE_AW;
	localparam logic [AW-1:0] CLEAR_LAST = AW'(CLEAR_LEN - 1);

	// Shared storage: array written on sys_clk, read on the link clock while idle
	logic [7:0] mem [qrp_pkg::MEM_BYTES];
	logic unit_used [qrp_pkg::MEM_BYTES >> qrp_pkg::UNIT_AW];
	logic [7:0] page_buf [1 << PW];

	// Link domain state
	qrp_pkg::qrp_link_e state_r;
	logic [5:0] cnt_r;
	logic [31:0] shift_r;
	logic [AW-1:0] addr_r;
	logic nib_hi_r;
	logic cur_wide_r;
	logic first_r;
	logic skip_wide_r;
	logic prog_armed_r;
	logic prog_partial_r;
	logic [AW-1:0] prog_base_r;
	logic [PW-1:0] prog_off_r;
	logic [(1 << PW)-1:0] loaded_r;
	qrp_pkg::qrp_cfg_s cfg_meta_r;
	qrp_pkg::qrp_cfg_s cfg_lk_r;
	logic wip_meta_r;
	logic wip_lk_r;

	// System domain state
	qrp_pkg::qrp_sys_e sys_state_r;
	qrp_pkg::qrp_sys_e sys_nxt;
	logic [AW-1:0] idx_r;
	logic [qrp_pkg::WAIT_W-1:0] wait_r;
	logic unit_skip_r;
	logic [2:0] cs_sync_r;
	logic [1:0] armed_sync_r;
	logic [1:0] partial_sync_r;

	// Total dummy clocks, mode cycles included; too small a setting is held at the mode length
	function automatic logic [5:0] dummy_total(input logic [3:0] setting);
		logic [5:0] d;
		d = {2'h0, setting};
		if (setting == qrp_pkg::DUMMY_USE_DEFAULT) begin
			d = {2'h0, qrp_pkg::DUMMY_DEFAULT};
		end else if (d < qrp_pkg::MODE_CYCLES) begin
			d = qrp_pkg::MODE_CYCLES;
		end
		return d;
	endfunction : dummy_total

	// Top-aligned level protection plus per-sector guard bits
	function automatic logic page_locked(input logic [AW-1:0] a, input logic [3:0] lvl,
			input logic [qrp_pkg::NUM_SECTORS-1:0] asg);
		logic [AW:0] span;
		span = '0;
		if (lvl >= qrp_pkg::PROT_FULL_LEVEL) begin
			span = qrp_pkg::MEM_SPAN;
		end else if (lvl != 4'h0) begin
			span = qrp_pkg::SECTOR_SPAN << (lvl - 4'h1);
		end
		return ({1'b0, a} >= (qrp_pkg::MEM_SPAN - span)) || asg[a[AW-1:qrp_pkg::SECTOR_AW]];
	endfunction : page_locked

	// ---------------- Link clock domain ----------------

	logic [31:0] quad_sh;
	logic [31:0] single_sh;
	logic [7:0] cmd_byte;
	logic cmd_last;
	logic addr_last;
	logic paddr_last;
	logic dummy_last;
	logic byte_done;
	logic prog_accept;
	logic [5:0] dummy_all;

	// Shift forms and phase ends
	always_comb begin
		quad_sh = {shift_r[27:0], data_line_in}; // R3
		single_sh = {shift_r[30:0], data_line_in[0]};
		cmd_last = cfg_lk_r.four_line_command_mode ? (cnt_r == qrp_pkg::CMD_NIBBLES - 6'h1) // R12
			: (cnt_r == qrp_pkg::CMD_BITS - 6'h1);
		cmd_byte = cfg_lk_r.four_line_command_mode ? quad_sh[7:0] : single_sh[7:0];
		addr_last = cnt_r == (cur_wide_r ? qrp_pkg::ADDR_NIB_WIDE : qrp_pkg::ADDR_NIB_NARROW) - 6'h1;
		paddr_last = cnt_r == (cur_wide_r ? qrp_pkg::ADDR_BITS_WIDE : qrp_pkg::ADDR_BITS_NARROW) - 6'h1;
		dummy_all = dummy_total(cfg_lk_r.dummy_cycles); // R4
		dummy_last = cnt_r == dummy_all - qrp_pkg::MODE_CYCLES - 6'h1; // R9
		byte_done = state_r == qrp_pkg::LK_PDATA && cnt_r[2:0] == qrp_pkg::BYTE_LAST_BIT;
		prog_accept = state_r == qrp_pkg::LK_PADDR && paddr_last && !wip_lk_r;
	end

	// Configuration and busy flag into the link domain
	always_ff @(posedge serial_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_meta_r <= '0;
			cfg_lk_r <= '0;
			wip_meta_r <= 1'b1;
			wip_lk_r <= 1'b1;
		end else begin
			cfg_meta_r <= link_cfg;
			cfg_lk_r <= cfg_meta_r; // R10
			wip_meta_r <= write_in_progress;
			wip_lk_r <= wip_meta_r;
		end
	end

	// Frame sequencer; deselect drops any unfinished phase at once, reset clears it while the link clock is idle
	always_ff @(posedge serial_clk or posedge chip_sel_b or negedge rst_b) begin
		if (chip_sel_b || !rst_b) begin
			state_r <= qrp_pkg::LK_CMD; // R23
			cnt_r <= '0;
			shift_r <= '0;
			addr_r <= '0;
			nib_hi_r <= 1'b1;
			cur_wide_r <= 1'b0;
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
			cnt_r <= cnt_r + 6'h1;
			unique case (state_r)
				qrp_pkg::LK_CMD: begin
					if (first_r && opcode_skip_read) begin
						// First nibble is already address in the skip state
						shift_r <= quad_sh; // R7
						cur_wide_r <= skip_wide_r;
						state_r <= qrp_pkg::LK_ADDR;
					end else begin
						shift_r <= cfg_lk_r.four_line_command_mode ? quad_sh : single_sh;
						if (cmd_last) begin
							cnt_r <= '0;
							shift_r <= '0;
							unique case (cmd_byte)
								qrp_pkg::OP_QUAD_READ, qrp_pkg::OP_QUAD_READ_WIDE: begin
									cur_wide_r <= cmd_byte == qrp_pkg::OP_QUAD_READ_WIDE
										|| cfg_lk_r.wide_address_select; // R2
									// Four-line mode needs no quad enable
									state_r <= (cfg_lk_r.four_line_command_mode || cfg_lk_r.quad_lines_allowed)
										? qrp_pkg::LK_ADDR : qrp_pkg::LK_SINK; // R13
								end
								qrp_pkg::OP_PAGE_PROGRAM, qrp_pkg::OP_PAGE_PROGRAM_WIDE: begin
									cur_wide_r <= cmd_byte == qrp_pkg::OP_PAGE_PROGRAM_WIDE
										|| cfg_lk_r.wide_address_select; // R15
									// Program is single-line only here
									state_r <= cfg_lk_r.four_line_command_mode ? qrp_pkg::LK_SINK
										: qrp_pkg::LK_PADDR;
								end
								default: state_r <= qrp_pkg::LK_SINK;
							endcase
						end
					end
				end
				qrp_pkg::LK_ADDR: begin
					shift_r <= quad_sh; // R3
					if (addr_last) begin
						cnt_r <= '0;
						addr_r <= quad_sh[AW-1:0];
						// Busy array: read is dropped, internal operation untouched
						state_r <= wip_lk_r ? qrp_pkg::LK_SINK : qrp_pkg::LK_MODE; // R11
					end
				end
				qrp_pkg::LK_MODE: begin
					if (cnt_r == qrp_pkg::MODE_CYCLES - 6'h1) begin
						cnt_r <= '0;
						state_r <= (dummy_all == qrp_pkg::MODE_CYCLES) ? qrp_pkg::LK_DATA : qrp_pkg::LK_DUMMY; // R9
					end
				end
				qrp_pkg::LK_DUMMY: begin
					if (dummy_last) begin
						state_r <= qrp_pkg::LK_DATA; // R4
					end
				end
				qrp_pkg::LK_DATA: begin
					nib_hi_r <= !nib_hi_r;
					if (!nib_hi_r) begin
						addr_r <= addr_r + AW'(1); // R6
					end
				end
				qrp_pkg::LK_PADDR: begin
					shift_r <= single_sh;
					if (paddr_last) begin
						cnt_r <= '0;
						state_r <= wip_lk_r ? qrp_pkg::LK_SINK : qrp_pkg::LK_PDATA;
					end
				end
				qrp_pkg::LK_PDATA: begin
					shift_r <= single_sh; // R18
				end
				qrp_pkg::LK_SINK: begin
					cnt_r <= '0;
				end
			endcase
		end
	end

	// Opcode-skip state survives frames; only the upper mode nibble counts
	always_ff @(posedge serial_clk or negedge rst_b) begin
		if (!rst_b) begin
			opcode_skip_read <= 1'b0;
			skip_wide_r <= 1'b0;
		end else if (!chip_sel_b && state_r == qrp_pkg::LK_MODE && cnt_r == '0) begin
			opcode_skip_read <= data_line_in == qrp_pkg::MODE_SKIP_PATTERN; // R7 R8
			skip_wide_r <= cur_wide_r;
		end
	end

	// Program capture; armed only on whole bytes so a ragged end drops the command
	always_ff @(posedge serial_clk or negedge rst_b) begin
		if (!rst_b) begin
			prog_armed_r <= 1'b0;
			prog_partial_r <= 1'b0;
			prog_base_r <= '0;
			prog_off_r <= '0;
			loaded_r <= '0;
		end else if (!chip_sel_b) begin
			if (first_r) begin
				prog_armed_r <= 1'b0;
				prog_partial_r <= 1'b0;
			end
			if (prog_accept) begin
				prog_base_r <= single_sh[AW-1:0];
				prog_off_r <= single_sh[PW-1:0];
				loaded_r <= '0;
			end
			if (byte_done) begin
				prog_off_r <= prog_off_r + PW'(1); // R20
				loaded_r[prog_off_r] <= 1'b1;
				prog_armed_r <= 1'b1; // R18
				prog_partial_r <= 1'b0;
			end else if (state_r == qrp_pkg::LK_PDATA) begin
				prog_partial_r <= 1'b1;
			end
		end
	end

	// Page buffer; a wrap overwrites the oldest bytes
	always_ff @(posedge serial_clk) begin
		if (!chip_sel_b && byte_done) begin
			page_buf[prog_off_r] <= single_sh[7:0]; // R20
		end
	end

	// Read nibbles leave on the falling edge; lines float outside the data phase
	always_ff @(negedge serial_clk or posedge chip_sel_b or negedge rst_b) begin
		if (chip_sel_b || !rst_b) begin
			data_line_out <= 4'h0;
			data_line_oe <= 4'h0;
		end else if (state_r == qrp_pkg::LK_DATA) begin
			data_line_oe <= 4'hf;
			data_line_out <= nib_hi_r ? mem[addr_r][7:4] : mem[addr_r][3:0]; // R5
		end else begin
			data_line_out <= 4'h0;
			data_line_oe <= 4'h0;
		end
	end

	// ---------------- System clock domain ----------------

	logic cs_rise;
	logic prog_try;
	logic prog_go;
	logic [PW-1:0] wr_off;
	logic [AW-1:0] wr_addr;
	logic skip_now;
	logic do_write;

	// Deselect edge and armed level are both taken from the second stage; the third stage only marks the edge
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cs_sync_r <= 3'h7;
			armed_sync_r <= 2'h0;
			partial_sync_r <= 2'h0;
		end else begin
			cs_sync_r <= {cs_sync_r[1:0], chip_sel_b};
			armed_sync_r <= {armed_sync_r[0], prog_armed_r};
			partial_sync_r <= {partial_sync_r[0], prog_partial_r};
		end
	end

	// Launch decision and write-side addressing
	always_comb begin
		cs_rise = cs_sync_r[1] && !cs_sync_r[2];
		prog_try = cs_rise && armed_sync_r[1] && !partial_sync_r[1]; // R18
		prog_go = prog_try && guard.write_enable_latch
			&& !page_locked(prog_base_r, {guard.protect_level_bit3, guard.protect_level_bit2,
				guard.protect_level_bit1, guard.protect_level_bit0}, guard.advanced_sector_guard); // R17
		wr_off = idx_r[PW-1:0];
		wr_addr = {prog_base_r[AW-1:PW], wr_off};
		// Unit verdict taken at its first byte and held for the rest of it
		skip_now = (wr_off[qrp_pkg::UNIT_AW-1:0] == '0)
			? (guard.ecc_on && unit_used[wr_addr[AW-1:qrp_pkg::UNIT_AW]]) : unit_skip_r; // R22
		do_write = sys_state_r == qrp_pkg::SY_WRITE && loaded_r[wr_off] && !skip_now; // R20
	end

	// Internal operation sequencing
	always_comb begin
		sys_nxt = sys_state_r;
		unique case (sys_state_r)
			qrp_pkg::SY_INIT: if (idx_r == CLEAR_LAST) sys_nxt = qrp_pkg::SY_IDLE;
			qrp_pkg::SY_IDLE: if (prog_go) sys_nxt = qrp_pkg::SY_WRITE;
			qrp_pkg::SY_WRITE: if (wr_off == qrp_pkg::PAGE_LAST) sys_nxt = qrp_pkg::SY_WAIT;
			qrp_pkg::SY_WAIT: if (wait_r == qrp_pkg::PROG_LAST) sys_nxt = qrp_pkg::SY_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sys_state_r <= qrp_pkg::SY_INIT;
		end else begin
			sys_state_r <= sys_nxt;
		end
	end

	// Sweep and page index
	always_ff @(posedge sys_clk) begin
		if (!rst_b || sys_state_r == qrp_pkg::SY_IDLE) begin
			idx_r <= '0;
		end else if (sys_state_r != qrp_pkg::SY_WAIT) begin
			idx_r <= idx_r + AW'(1);
		end
	end

	// Program time counter
	always_ff @(posedge sys_clk) begin
		if (!rst_b || sys_state_r != qrp_pkg::SY_WAIT) begin
			wait_r <= '0;
		end else begin
			wait_r <= wait_r + qrp_pkg::WAIT_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			unit_skip_r <= 1'b0;
		end else if (sys_state_r == qrp_pkg::SY_WRITE) begin
			unit_skip_r <= skip_now;
		end
	end

	// Array writes: erase sweep after reset, then AND-only programming
	always_ff @(posedge sys_clk) begin
		if (sys_state_r == qrp_pkg::SY_INIT) begin
			mem[idx_r] <= qrp_pkg::ERASED_BYTE;
			unit_used[idx_r[AW-1:qrp_pkg::UNIT_AW]] <= 1'b0;
		end else if (do_write) begin
			mem[wr_addr] <= mem[wr_addr] & page_buf[wr_off]; // R21
			unit_used[wr_addr[AW-1:qrp_pkg::UNIT_AW]] <= 1'b1; // R22
		end
	end

	// Status outputs
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			write_in_progress <= 1'b1;
			program_started <= 1'b0;
			program_rejected <= 1'b0;
		end else begin
			write_in_progress <= sys_nxt != qrp_pkg::SY_IDLE; // R19
			program_started <= sys_state_r == qrp_pkg::SY_IDLE && prog_go;
			program_rejected <= sys_state_r == qrp_pkg::SY_IDLE && prog_try && !prog_go; // R17
		end
	end

endmodule : qrp_quad_read_program

// [hw/qrp_pkg.sv]
// Summary of operation
// R1 - Host sets quad enable before single-line quad read
// R2 - EBh address width follows select; ECh four bytes
// R3 - Address, mode, dummy nibbles rise-sampled, MSB on line 3
// R4 - Dummy count configurable, six clocks by default
// R5 - Read nibbles driven on falling edges, MSB line 3
// R6 - Address increments per byte, wraps to zero
// R7 - Mode upper nibble 1010 makes next read skip opcode
// R8 - Other mode nibble leaves skip state, opcode expected
// R9 - Dummy count includes the two mode cycles
// R10 - After read, command protocol setting stays unchanged
// R11 - Reads during busy internal operation are ignored
// R12 - Four-line mode takes opcode as two nibbles
// R13 - Four-line mode reads regardless of quad enable
// R14 - Host provides enough dummies, floats lower mode nibble
// R15 - 02h address width follows select; 12h four bytes
// R16 - Host sets write enable latch before programming
// R17 - Program into protected page is ignored
// R18 - Program starts only at chip-select rise after data
// R19 - Write-in-progress high while programming, low when done
// R20 - Program data wraps in page, last bytes kept
// R21 - Programming only clears bits to zero
// R22 - With correction on, each 8-byte unit programs once
// R23 - Chip-select rise abandons an incomplete command phase
package qrp_pkg;

	// Array geometry
	localparam int MEM_AW = 14;
	localparam int MEM_BYTES = 1 << MEM_AW;
	localparam int PAGE_AW = 8;
	localparam int UNIT_AW = 3;
	localparam int SECTOR_AW = 12;
	localparam int NUM_SECTORS = MEM_BYTES >> SECTOR_AW;
	localparam logic [MEM_AW:0] MEM_SPAN = (MEM_AW + 1)'(MEM_BYTES);
	localparam logic [MEM_AW:0] SECTOR_SPAN = (MEM_AW + 1)'(1 << SECTOR_AW);
	localparam logic [3:0] PROT_FULL_LEVEL = 4'(MEM_AW - SECTOR_AW + 1);
	localparam logic [PAGE_AW-1:0] PAGE_LAST = 8'hff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// Opcodes
	localparam logic [7:0] OP_QUAD_READ = 8'heb;
	localparam logic [7:0] OP_QUAD_READ_WIDE = 8'hec;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_PAGE_PROGRAM_WIDE = 8'h12;

	// Phase lengths in link clocks
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] CMD_NIBBLES = 6'h02;
	localparam logic [5:0] ADDR_NIB_NARROW = 6'h06;
	localparam logic [5:0] ADDR_NIB_WIDE = 6'h08;
	localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
	localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
	localparam logic [5:0] MODE_CYCLES = 6'h02;
	localparam logic [3:0] DUMMY_DEFAULT = 4'h6;
	localparam logic [3:0] DUMMY_USE_DEFAULT = 4'h0;
	localparam logic [3:0] MODE_SKIP_PATTERN = 4'ha;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

	// Internal program time
	localparam int CLK_PERIOD_NS = 8;
	localparam int PROG_TIME_NS = 20000;
	localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAIT_W = 12;
	localparam logic [WAIT_W-1:0] PROG_LAST = WAIT_W'(PROG_CYCLES - 1);

	typedef enum logic [2:0] {LK_CMD, LK_ADDR, LK_MODE, LK_DUMMY, LK_DATA, LK_PADDR, LK_PDATA, LK_SINK} qrp_link_e;
	typedef enum logic [1:0] {SY_INIT, SY_IDLE, SY_WRITE, SY_WAIT} qrp_sys_e;

	// Link-side configuration
	typedef struct packed {
		logic quad_lines_allowed;
		logic wide_address_select;
		logic four_line_command_mode;
		logic [3:0] dummy_cycles;
	} qrp_cfg_s;

	// Write permission and protection state
	typedef struct packed {
		logic write_enable_latch;
		logic ecc_on;
		logic protect_level_bit3;
		logic protect_level_bit2;
		logic protect_level_bit1;
		logic protect_level_bit0;
		logic [NUM_SECTORS-1:0] advanced_sector_guard;
	} qrp_guard_s;

endpackage : qrp_pkg

// [testbench/qrp_quad_read_program_chk.sv]
`timescale 1ns/1ps
// Port-level checks, all on the system clock
module qrp_quad_read_program_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Link pins
	input wire logic chip_sel_b,
	input wire logic [3:0] data_line_oe,
	// Status and guard
	input wire qrp_pkg::qrp_guard_s guard,
	input wire logic write_in_progress,
	input wire logic opcode_skip_read,
	input wire logic program_started,
	input wire logic program_rejected
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic busy_frame_r;
	// Frame opened while busy; dropped once busy ends, since a late end of address may legally accept
	always_ff @(posedge sys_clk) begin
		if (!rst_b || chip_sel_b || !write_in_progress) busy_frame_r <= 1'b0;
		else if ($fell(chip_sel_b)) busy_frame_r <= 1'b1;
	end
	sequence s_launch;
		program_started ##1 write_in_progress [*4];
	endsequence
	AST_LAUNCH_BUSY: assert property (program_started |-> s_launch)
		else $error("busy missing after launch");
	AST_WIP_RESET: assert property (disable iff (1'b0) !rst_b |=> write_in_progress)
		else $error("busy low in reset");
	AST_OE_IDLE: assert property (chip_sel_b && $past(chip_sel_b) |-> data_line_oe == 4'h0)
		else $error("driving while deselected");
	AST_OE_WHOLE: assert property (data_line_oe == 4'h0 || data_line_oe == 4'hf)
		else $error("partial line drive");
	AST_OE_HOLD: assert property (data_line_oe[0] && !chip_sel_b |=> data_line_oe[0] || chip_sel_b)
		else $error("data stopped inside frame");
	AST_BUSY_QUIET: assert property (busy_frame_r |-> data_line_oe == 4'h0)
		else $error("read served while busy");
	AST_REJ_IDLE: assert property (program_rejected |-> ##1 !write_in_progress [*3])
		else $error("refused program went busy");
	AST_START_CS: assert property (program_started |-> $past(chip_sel_b, 3) && chip_sel_b)
		else $error("launch without deselect");
	AST_WEL: assert property (program_started |-> guard.write_enable_latch)
		else $error("launch without write enable");
	AST_SKIP_FRAME: assert property ($changed(opcode_skip_read) |-> !chip_sel_b)
		else $error("skip state moved outside frame");
endmodule : qrp_quad_read_program_chk

bind qrp_quad_read_program qrp_quad_read_program_chk u_chk (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.chip_sel_b(chip_sel_b),
	.data_line_oe(data_line_oe),
	.guard(guard),
	.write_in_progress(write_in_progress),
	.opcode_skip_read(opcode_skip_read),
	.program_started(program_started),
	.program_rejected(program_rejected)
);

// [testbench/qrp_host_model.sv]
`timescale 1ns/1ps
// Host controller: mode 0 link clock that idles low and runs only inside xfer
module qrp_host_model (
	// Link pins
	output logic serial_clk,
	output logic chip_sel_b,
	output logic [3:0] data_line_in,
	input wire logic [3:0] data_line_out,
	input wire logic [3:0] data_line_oe
);
	logic [3:0] h_val = 4'h0;
	logic [3:0] h_oe = 4'h0;
	initial serial_clk = 1'b0;
	initial chip_sel_b = 1'b1;
	// Wire level; a released line has no pull, so it shows the inverse of its last value
	assign data_line_in = data_line_oe & data_line_out | ~data_line_oe & ~(h_oe ^ h_val);
	// One link clock: change while low, sample at the rising edge
	task automatic xfer(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] qo);
		h_val = v;
		h_oe = oe;
		#24 serial_clk = 1'b1;
		qo = data_line_in;
		#24 serial_clk = 1'b0;
	endtask : xfer
	// Frame edge; lines released, deselect lasts six system clocks
	task automatic sel(input logic b);
		h_oe = 4'h0;
		chip_sel_b = b;
		#48;
	endtask : sel
endmodule : qrp_host_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
// Bench: host model drives the link, bench drives config and checks data
module tb_top;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b1;
	logic serial_clk, chip_sel_b, write_in_progress, opcode_skip_read, program_started, program_rejected;
	logic [3:0] data_line_in, data_line_out, data_line_oe, q;
	qrp_pkg::qrp_cfg_s link_cfg = '0;
	qrp_pkg::qrp_guard_s guard = '0;
	int err_total = 0;
	int n_compared = 0;
	int oe_cnt = 0;
	int n_done = 0;
	int t;
	logic [31:0] seed = 32'hd805;
	logic [31:0] r;
	logic [31:0] ra;
	logic [7:0] mem [0:16383];
	bit unit_done [0:2047];
	logic [7:0] rbuf [0:7];
	always #4 sys_clk = ~sys_clk;
	// Count link cycles with the device driving, and launch verdicts
	always @(posedge serial_clk) if (data_line_oe != 4'h0) oe_cnt++;
	always @(posedge sys_clk) if (program_started || program_rejected) n_done++;
	qrp_quad_read_program #(.CLEAR_LEN(16384)) u_qrp_quad_read_program (.sys_clk(sys_clk), .rst_b(rst_b),
		.serial_clk(serial_clk), .chip_sel_b(chip_sel_b), .data_line_in(data_line_in),
		.data_line_out(data_line_out), .data_line_oe(data_line_oe), .link_cfg(link_cfg), .guard(guard),
		.write_in_progress(write_in_progress), .opcode_skip_read(opcode_skip_read),
		.program_started(program_started), .program_rejected(program_rejected));
	qrp_host_model u_qrp_host_model (.serial_clk(serial_clk), .chip_sel_b(chip_sel_b),
		.data_line_in(data_line_in), .data_line_out(data_line_out), .data_line_oe(data_line_oe));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Protected map: level L covers the top 4 KB << (L-1), level 3 and up all; one guard bit per 4 KB sector
	function automatic bit locked(input logic [31:0] a, input logic [3:0] lvl, input logic [3:0] sg);
		int top;
		top = lvl == 4'h0 ? 16384 : lvl >= 4'h3 ? 0 : 16384 - (4096 << (lvl - 1));
		return a[13:0] >= top || sg[a[13:12]];
	endfunction : locked
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic results();
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results
	// Bounded wait for the busy flag to drop
	task automatic idle();
		t = 0;
		while (write_in_progress !== 1'b0 && t < 20000) begin
			@(negedge sys_clk);
			t++;
		end
		if (t == 20000) begin
			err_total++;
			results();
		end
	endtask : idle
	// Config crosses on link clocks, so clock the deselected link a few times
	task automatic setc(input qrp_pkg::qrp_cfg_s c);
		@(negedge sys_clk);
		link_cfg = c;
		repeat (3) u_qrp_host_model.xfer(4'h0, 4'h0, q);
	endtask : setc
	task automatic setg(input qrp_pkg::qrp_guard_s g);
		@(negedge sys_clk);
		guard = g;
	endtask : setg
	task automatic bits(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) u_qrp_host_model.xfer({3'h0, v[i]}, 4'h1, q);
	endtask : bits
	// Quad read; skip leaves out the opcode, nb bytes land in rbuf
	task automatic rd(input logic [7:0] op, input logic [31:0] a, input int na, input logic [7:0] m, input int nb,
		input bit skip);
		int dm;
		dm = link_cfg.dummy_cycles == 4'h0 ? 6 : link_cfg.dummy_cycles;
		u_qrp_host_model.sel(1'b0);
		if (!skip && link_cfg.four_line_command_mode) begin
			u_qrp_host_model.xfer(op[7:4], 4'hf, q);
			u_qrp_host_model.xfer(op[3:0], 4'hf, q);
		end else if (!skip) bits(op, 8);
		for (int i = na - 1; i >= 0; i--) u_qrp_host_model.xfer(a[4*i+:4], 4'hf, q);
		u_qrp_host_model.xfer(m[7:4], 4'hf, q);
		u_qrp_host_model.xfer(m[3:0], 4'h0, q);
		for (int i = 2; i < dm; i++) u_qrp_host_model.xfer(4'h0, 4'h0, q);
		for (int i = 0; i < nb; i++) begin
			u_qrp_host_model.xfer(4'h0, 4'h0, rbuf[i][7:4]);
			u_qrp_host_model.xfer(4'h0, 4'h0, rbuf[i][3:0]);
		end
		u_qrp_host_model.sel(1'b1);
	endtask : rd
	task automatic look(input logic [31:0] a, input int n);
		for (int i = 0; i < n; i++) chk("read byte", rbuf[i], mem[(a + i) % 16384]);
	endtask : look
	task automatic scan();
		for (int b = 0; b < 64; b += 8) begin
			rd(8'heb, b, 6, 8'h00, 8, 1'b0);
			look(b, 8);
		end
	endtask : scan
	// Page program on line 0; ok says whether the device should launch it
	task automatic pp(input logic [7:0] op, input logic [31:0] a, input int na, input int n, input bit ok);
		logic [7:0] lat [0:255];
		bit hit [0:255];
		int k;
		int d;
		logic [31:0] pg;
		d = n_done;
		pg = a & 32'h3f00;
		u_qrp_host_model.sel(1'b0);
		bits(op, 8);
		bits(a, 8 * na);
		for (int i = 0; i < n; i++) begin
			k = (a[7:0] + i) % 256;
			lat[k] = 8'(rnd());
			hit[k] = 1'b1;
			bits(lat[k], 8);
		end
		u_qrp_host_model.sel(1'b1);
		t = 0;
		while (n_done == d && t < 50) begin
			@(negedge sys_clk);
			t++;
		end
		if (t == 50) begin
			err_total++;
			results();
		end
		repeat (2) @(negedge sys_clk);
		chk("launch busy", write_in_progress, ok);
		// Expected array: bits only clear, a unit already written is skipped with correction on
		for (int j = 0; j < 256; j++)
			if (ok && hit[j] && !(guard.ecc_on && unit_done[(pg + j) >> 3])) mem[pg + j] &= lat[j];
		for (int j = 0; j < 256; j++) if (ok && hit[j]) unit_done[(pg + j) >> 3] = 1'b1;
	endtask : pp
	initial begin
		#1 rst_b = 1'b0;
		for (int i = 0; i < 16384; i++) mem[i] = 8'hff;
		repeat (8) @(negedge sys_clk);
		rst_b = 1'b1;
		idle();
		setg('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, '0});
		setc('{1'b1, 1'b0, 1'b0, 4'h0});
		for (int r = 0; r < 4; r++) begin
			pp(8'h02, rnd() % 48, 3, 1 + rnd() % 8, 1'b1);
			idle();
		end
		scan();
		pp(8'h02, 32'h3f80, 3, 1, 1'b1);
		t = oe_cnt;
		rd(8'heb, 32'h0, 6, 8'h00, 1, 1'b0);
		chk("busy read", oe_cnt, t);
		idle();
		pp(8'h12, 32'h3ffe, 4, 3, 1'b1);
		idle();
		rd(8'hec, 32'h3fff, 8, 8'ha5, 2, 1'b0);
		look(32'h3fff, 2);
		chk("skip set", opcode_skip_read, 1'b1);
		rd(8'hec, 32'h3f00, 8, 8'h3c, 1, 1'b1);
		look(32'h3f00, 1);
		chk("skip clear", opcode_skip_read, 1'b0);
		setc('{1'b1, 1'b1, 1'b0, 4'h0});
		rd(8'heb, 32'h10, 8, 8'h00, 2, 1'b0);
		look(32'h10, 2);
		setc('{1'b0, 1'b0, 1'b1, 4'h8});
		for (int r = 0; r < 2; r++) begin
			rd(8'heb, 32'h8, 6, 8'h00, 4, 1'b0);
			look(32'h8, 4);
		end
		setc('{1'b0, 1'b0, 1'b0, 4'h0});
		t = oe_cnt;
		rd(8'heb, 32'h0, 6, 8'h00, 1, 1'b0);
		chk("refused read", oe_cnt, t);
		setc('{1'b1, 1'b0, 1'b0, 4'h0});
		// Frame cut short after the opcode and one address nibble
		u_qrp_host_model.sel(1'b0);
		bits(8'heb, 8);
		u_qrp_host_model.xfer(4'h0, 4'hf, q);
		u_qrp_host_model.sel(1'b1);
		rd(8'heb, 32'h20, 6, 8'h00, 8, 1'b0);
		look(32'h20, 8);
		setg('{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, '0});
		pp(8'h02, 32'h20, 3, 2, 1'b0);
		setg('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, '0});
		pp(8'h02, 32'h3f10, 3, 2, 1'b0);
		setg('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, qrp_pkg::NUM_SECTORS'(1)});
		pp(8'h02, 32'h4, 3, 2, 1'b0);
		setg('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, '0});
		pp(8'h02, 32'h38, 3, 2, 1'b1);
		idle();
		pp(8'h02, 32'h3a, 3, 2, 1'b1);
		idle();
		// Random guard map, start address, protocol and dummy setting; launch expected from the map
		for (int n = 0; n < 4; n++) begin
			r = rnd();
			ra = {18'h0, r[31:18]};
			setc('{1'b1, 1'b0, 1'b0, 4'h0});
			setg('{1'b1, 1'b0, r[8] & r[3], r[8] & r[2], r[8] & r[1], r[8] & r[0], r[7:4] & r[11:8]});
			pp(8'h02, ra, 3, 1 + r[13:12], !locked(ra, {4{r[8]}} & r[3:0], r[7:4] & r[11:8]));
			idle();
			setc('{1'b1, r[16], r[17], r[15:12]});
			rd(8'heb, ra, r[16] ? 8 : 6, 8'h00, 2, 1'b0);
			look(ra, 2);
		end
		scan();
		results();
	end
endmodule : tb_top
